/* run_select_defs.svh */
`ifndef RUN_SELECT_DEFS_SVH
`define RUN_SELECT_DEFS_SVH
`define SRC_KEYPAD 3'h0
`define SRC_TWO_WIRE 3'h1
`define SRC_RUN_DIR 3'h2
`define SRC_RS485 3'h3
`define SRC_FIELDBUS 3'h4
`define SRC_PLC 3'h5
`define FUNC_FORWARD 5'h01
`define FUNC_REVERSE 5'h02
`define MULTI_KEY_LOCAL_REMOTE 2'h1
`define PREVENT_NONE 2'h0
`define PREVENT_FORWARD 2'h1
`define PREVENT_REVERSE 2'h2
`define RUN_ON_DELAY_RESET 14'h0064
`define TICK_10MS_NS 10000000
`define CLOCK_PERIOD_NS 10
`define TICK_10MS_CYCLES (`TICK_10MS_NS / `CLOCK_PERIOD_NS)
`define POWER_CHECK_START 2'h3
`define POWER_CHECK_AT 2'h1
`endif

/* run_select_pkg.sv */
package run_select_pkg;
  typedef enum logic [1:0] {
    DIR_STOP = 2'b00,
    DIR_FWD = 2'b01,
    DIR_REV = 2'b10
  } dir_cmd_t;
endpackage : run_select_pkg

/* input_sync.sv */
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : input_sync

/* run_on_delay.sv */
`timescale 1ns/1ps
`include "run_select_defs.svh"
module run_on_delay #(
  parameter int TICK_CYCLES = `TICK_10MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic request,
  input wire logic [13:0] delay_ticks,
  output logic done
);
  // Counts 10 ms ticks while request holds; drops at once when request falls
  logic [23:0] pre_q;
  logic [13:0] ticks_q;
  logic tick;
  logic reached;

  assign tick = (pre_q == 24'(TICK_CYCLES - 1));
  assign reached = (ticks_q >= delay_ticks);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= 24'h000000;
      ticks_q <= 14'h0000;
      done <= 1'b0;
    end
    else if (!request)
    begin
      pre_q <= 24'h000000;
      ticks_q <= 14'h0000;
      done <= 1'b0;
    end
    else
    begin
      pre_q <= tick ? 24'h000000 : pre_q + 24'h000001;
      if (tick && !reached)
        ticks_q <= ticks_q + 14'h0001;
      done <= reached;
    end
  end
endmodule : run_on_delay

/* run_command_source_selector.sv */
`timescale 1ns/1ps
`include "run_select_defs.svh"
module run_command_source_selector
  import run_select_pkg::*;
#(
  parameter int NUM_INPUTS = 11,
  parameter int TICK_CYCLES = `TICK_10MS_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [2:0] CMD_SOURCE,
  input wire logic [NUM_INPUTS-1:0] TERMINAL_IN,
  input wire logic [NUM_INPUTS*5-1:0] INPUT_FUNCTION_ASSIGN,
  input wire logic FORWARD_INCH_INPUT,
  input wire logic REVERSE_INCH_INPUT,
  input wire logic PREMAGNETIZE_INPUT,
  input wire logic [13:0] RUN_ON_DELAY,
  input wire logic KEY_FWD,
  input wire logic KEY_REV,
  input wire logic KEY_STOP,
  input wire logic KEY_MULTI,
  input wire logic [1:0] MULTI_KEY_SEL,
  input wire logic RUN_ENABLE_USED,
  input wire logic RUN_ENABLE_INPUT,
  input wire logic COMM_RUN_FWD,
  input wire logic COMM_RUN_REV,
  input wire logic COMM_STOP,
  input wire logic [1:0] RUN_PREVENT,
  input wire logic POWER_ON_RUN,
  input wire logic TRIP_RESET,
  output logic RUN_FWD,
  output logic RUN_REV,
  output logic REMOTE_INDICATOR,
  output logic KEYPAD_SOURCE_INDICATOR,
  output logic TERMINAL_BLOCKED
);
  localparam int NSYNC = NUM_INPUTS + 9;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_in;
  logic [NUM_INPUTS-1:0] term_s;
  logic [NUM_INPUTS-1:0] fwd_hit;
  logic [NUM_INPUTS-1:0] rev_hit;
  logic fx;
  logic rx;
  logic inch_fwd_s;
  logic inch_rev_s;
  logic premag_s;
  logic kfwd_s;
  logic krev_s;
  logic kstop_s;
  logic kmulti_s;
  logic run_en_s;
  logic trip_s;
  logic kmulti_prev_q;
  logic trip_prev_q;
  logic local_q;
  logic local_d;
  logic toggle_press;
  logic toggle_enabled;
  logic trip_pulse;
  logic [1:0] boot_q;
  logic [1:0] boot_d;
  logic power_check;
  logic block_q;
  logic block_d;
  logic all_off;
  logic terminal_src;
  logic digital_src;
  dir_cmd_t key_cmd_q;
  dir_cmd_t key_cmd_d;
  dir_cmd_t comm_cmd_q;
  dir_cmd_t comm_cmd_d;
  dir_cmd_t term_cmd;
  dir_cmd_t term_gated;
  dir_cmd_t remote_cmd;
  dir_cmd_t raw_cmd;
  dir_cmd_t final_cmd;
  logic term_request;
  logic delay_done;
  logic blocked_dir;
  logic run_gate;

  assign raw_in = {TRIP_RESET, RUN_ENABLE_INPUT, KEY_MULTI, KEY_STOP, KEY_REV,
                   KEY_FWD, PREMAGNETIZE_INPUT, REVERSE_INCH_INPUT,
                   FORWARD_INCH_INPUT, TERMINAL_IN};

  input_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign term_s = sync_in[NUM_INPUTS-1:0];
  assign inch_fwd_s = sync_in[NUM_INPUTS];
  assign inch_rev_s = sync_in[NUM_INPUTS+1];
  assign premag_s = sync_in[NUM_INPUTS+2];
  assign kfwd_s = sync_in[NUM_INPUTS+3];
  assign krev_s = sync_in[NUM_INPUTS+4];
  assign kstop_s = sync_in[NUM_INPUTS+5];
  assign kmulti_s = sync_in[NUM_INPUTS+6];
  assign run_en_s = sync_in[NUM_INPUTS+7];
  assign trip_s = sync_in[NUM_INPUTS+8];

  // Any terminal whose function code is forward or reverse feeds that command
  genvar i;
  generate
    for (i = 0; i < NUM_INPUTS; i = i + 1)
    begin : g_assign
      assign fwd_hit[i] = term_s[i] &&
        (INPUT_FUNCTION_ASSIGN[i*5 +: 5] == `FUNC_FORWARD);
      assign rev_hit[i] = term_s[i] &&
        (INPUT_FUNCTION_ASSIGN[i*5 +: 5] == `FUNC_REVERSE);
    end
  endgenerate

  assign fx = |fwd_hit;
  assign rx = |rev_hit;

  assign terminal_src = (CMD_SOURCE == `SRC_TWO_WIRE) ||
                        (CMD_SOURCE == `SRC_RUN_DIR);
  assign digital_src = !terminal_src;
  assign all_off = !fx && !rx && !inch_fwd_s && !inch_rev_s && !premag_s;

  // Terminal command decode
  always_comb
  begin
    term_cmd = DIR_STOP;
    if (CMD_SOURCE == `SRC_TWO_WIRE)
    begin
      if (fx && !rx)
        term_cmd = DIR_FWD;
      else if (rx && !fx)
        term_cmd = DIR_REV;
    end
    else if (CMD_SOURCE == `SRC_RUN_DIR)
    begin
      if (fx)
        term_cmd = rx ? DIR_REV : DIR_FWD;
    end
  end

  assign term_gated = block_q ? DIR_STOP : term_cmd;
  assign term_request = (term_gated != DIR_STOP);

  run_on_delay #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_delay (
    .clk(CLOCK),
    .rst(RESET),
    .request(term_request),
    .delay_ticks(RUN_ON_DELAY),
    .done(delay_done)
  );

  assign toggle_enabled = (MULTI_KEY_SEL == `MULTI_KEY_LOCAL_REMOTE);
  assign toggle_press = toggle_enabled && kmulti_s && !kmulti_prev_q;
  assign trip_pulse = trip_s && !trip_prev_q;
  assign local_d = toggle_enabled ? (local_q ^ toggle_press) : 1'b0;

  // Power-up check waits until the synchroniser holds real pin levels
  assign power_check = (boot_q == `POWER_CHECK_AT);

  always_comb
  begin
    boot_d = boot_q;
    if (boot_q != 2'h0)
      boot_d = boot_q - 2'h1;
  end

  // Interlock: set at power-up with inputs held and power-on run off, or on trip reset in remote
  always_comb
  begin
    block_d = block_q;
    if (power_check)
      block_d = !POWER_ON_RUN && !all_off;
    else if (trip_pulse && !local_q)
      block_d = 1'b1;
    else if (all_off)
      block_d = 1'b0;
  end

  // Keypad latch; leaving remote clears it so local starts stopped
  always_comb
  begin
    key_cmd_d = key_cmd_q;
    if (local_d != local_q)
      key_cmd_d = DIR_STOP;
    else if (kstop_s)
      key_cmd_d = DIR_STOP;
    else if (kfwd_s)
      key_cmd_d = DIR_FWD;
    else if (krev_s)
      key_cmd_d = DIR_REV;
  end

  // Serial, bus and PLC commands latch; return to remote forces stop
  always_comb
  begin
    comm_cmd_d = comm_cmd_q;
    if (local_q && !local_d)
      comm_cmd_d = DIR_STOP;
    else if (COMM_STOP)
      comm_cmd_d = DIR_STOP;
    else if (COMM_RUN_FWD)
      comm_cmd_d = DIR_FWD;
    else if (COMM_RUN_REV)
      comm_cmd_d = DIR_REV;
  end

  always_comb
  begin
    case (CMD_SOURCE)
      `SRC_KEYPAD: remote_cmd = key_cmd_q;
      `SRC_TWO_WIRE,
      `SRC_RUN_DIR: remote_cmd = delay_done ? term_gated : DIR_STOP;
      `SRC_RS485,
      `SRC_FIELDBUS,
      `SRC_PLC: remote_cmd = comm_cmd_q;
      default: remote_cmd = DIR_STOP;
    endcase
  end

  // Local ignores inching inputs; run-enable gates keypad running in local only, not with the keypad as remote source
  assign run_gate = !RUN_ENABLE_USED || run_en_s;
  assign raw_cmd = local_q ? (run_gate ? key_cmd_q : DIR_STOP) : remote_cmd;

  assign blocked_dir =
    ((raw_cmd == DIR_FWD) && (RUN_PREVENT == `PREVENT_FORWARD)) ||
    ((raw_cmd == DIR_REV) && (RUN_PREVENT == `PREVENT_REVERSE));
  assign final_cmd = blocked_dir ? DIR_STOP : raw_cmd;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      kmulti_prev_q <= 1'b0;
      trip_prev_q <= 1'b0;
      local_q <= 1'b0;
      boot_q <= `POWER_CHECK_START;
      block_q <= 1'b0;
      key_cmd_q <= DIR_STOP;
      comm_cmd_q <= DIR_STOP;
    end
    else
    begin
      kmulti_prev_q <= kmulti_s;
      trip_prev_q <= trip_s;
      local_q <= local_d;
      boot_q <= boot_d;
      block_q <= block_d;
      key_cmd_q <= key_cmd_d;
      comm_cmd_q <= comm_cmd_d;
    end
  end

  // Registered outputs: run pair decoded from the qualified command, indicators from mode and interlock state
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      RUN_FWD <= 1'b0;
      RUN_REV <= 1'b0;
      REMOTE_INDICATOR <= 1'b0;
      KEYPAD_SOURCE_INDICATOR <= 1'b0;
      TERMINAL_BLOCKED <= 1'b0;
    end
    else
    begin
      RUN_FWD <= (final_cmd == DIR_FWD);
      RUN_REV <= (final_cmd == DIR_REV);
      REMOTE_INDICATOR <= toggle_enabled && !local_q;
      KEYPAD_SOURCE_INDICATOR <= local_q ||
        (CMD_SOURCE == `SRC_KEYPAD);
      TERMINAL_BLOCKED <= block_q;
    end
  end
endmodule : run_command_source_selector

/* run_command_source_selector_chk.sv */
`timescale 1ns/1ps
module run_command_source_selector_chk (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [2:0] CMD_SOURCE,
  input wire logic [1:0] MULTI_KEY_SEL,
  input wire logic COMM_RUN_FWD,
  input wire logic COMM_RUN_REV,
  input wire logic COMM_STOP,
  input wire logic [1:0] RUN_PREVENT,
  input wire logic RUN_FWD,
  input wire logic RUN_REV,
  input wire logic REMOTE_INDICATOR,
  input wire logic KEYPAD_SOURCE_INDICATOR
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  sequence s_comm_mode;
    CMD_SOURCE == 3'h3 && MULTI_KEY_SEL != 2'h1 && RUN_PREVENT == 2'h0;
  endsequence
  sequence s_fwd_req;
    COMM_RUN_FWD && !COMM_RUN_REV && !COMM_STOP;
  endsequence
  property p_excl;
    !(RUN_FWD && RUN_REV);
  endproperty
  property p_no_fwd;
    (RUN_PREVENT == 2'h1)[*3] |-> !RUN_FWD;
  endproperty
  property p_no_rev;
    (RUN_PREVENT == 2'h2)[*3] |-> !RUN_REV;
  endproperty
  property p_bad_src;
    (CMD_SOURCE > 3'h5)[*3] |-> !RUN_FWD && !RUN_REV;
  endproperty
  property p_no_remote;
    (MULTI_KEY_SEL != 2'h1)[*3] |-> !REMOTE_INDICATOR;
  endproperty
  property p_keypad_ind;
    (CMD_SOURCE == 3'h0)[*3] |-> KEYPAD_SOURCE_INDICATOR;
  endproperty
  property p_comm_fwd;
    s_comm_mode and s_fwd_req |-> ##[1:3] RUN_FWD;
  endproperty
  property p_comm_stop;
    s_comm_mode ##0 COMM_STOP |-> ##[1:3] !RUN_FWD && !RUN_REV;
  endproperty
  a_excl: assert property (p_excl)
    else $error("both directions at once");
  a_no_fwd: assert property (p_no_fwd)
    else $error("forward while prevented");
  a_no_rev: assert property (p_no_rev)
    else $error("reverse while prevented");
  a_bad_src: assert property (p_bad_src)
    else $error("run from unused source");
  a_no_remote: assert property (p_no_remote)
    else $error("remote shown without toggle role");
  a_keypad_ind: assert property (p_keypad_ind)
    else $error("keypad source not shown");
  a_comm_fwd: assert property (p_comm_fwd)
    else $error("serial forward not followed");
  a_comm_stop: assert property (p_comm_stop)
    else $error("serial stop not followed");
endmodule : run_command_source_selector_chk

/* field_side.sv */
`timescale 1ns/1ps
module field_side (
  input wire logic clk,
  output logic [10:0] pins,
  output logic [3:0] keys,
  output logic [2:0] comm,
  output logic trip
);
  initial
  begin
    pins = 11'h000;
    keys = 4'h0;
    comm = 3'h0;
    trip = 1'b0;
  end
  task automatic put(input logic [10:0] v);
    @(posedge clk);
    pins <= v;
  endtask : put
  // Held long enough to pass the input synchroniser
  task automatic press(input int k);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (6) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : press
  task automatic send(input int c);
    @(posedge clk);
    comm[c] <= 1'b1;
    @(posedge clk);
    comm[c] <= 1'b0;
  endtask : send
  task automatic trip_reset;
    @(posedge clk);
    trip <= 1'b1;
    repeat (6) @(posedge clk);
    trip <= 1'b0;
  endtask : trip_reset
endmodule : field_side

/* run_command_source_selector_test.sv */
`timescale 1ns/1ps
`include "run_select_defs.svh"
module run_command_source_selector_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [2:0] src = 3'h3;
  logic [54:0] func = 55'h0;
  logic [13:0] dly = 14'h0000;
  logic [1:0] msel = 2'h0;
  logic en_used = 1'b0;
  logic en_in = 1'b0;
  logic inch_f = 1'b0;
  logic inch_r = 1'b0;
  logic premag = 1'b0;
  logic pwr_run = 1'b1;
  logic [1:0] prev = 2'h0;
  logic [10:0] pins;
  logic [3:0] keys;
  logic [2:0] comm;
  logic trip, run_fwd, run_rev, rem_ind, key_ind, blocked;
  int num_errors = 0;
  int checked = 0;
  always #5 clock = ~clock;
  field_side field (.clk(clock), .pins(pins), .keys(keys), .comm(comm),
    .trip(trip));
  run_command_source_selector #(.TICK_CYCLES(4)) DUT (.CLOCK(clock),
    .RESET(reset), .CMD_SOURCE(src), .TERMINAL_IN(pins),
    .INPUT_FUNCTION_ASSIGN(func), .FORWARD_INCH_INPUT(inch_f),
    .REVERSE_INCH_INPUT(inch_r), .PREMAGNETIZE_INPUT(premag),
    .RUN_ON_DELAY(dly), .KEY_FWD(keys[0]), .KEY_REV(keys[1]),
    .KEY_STOP(keys[2]), .KEY_MULTI(keys[3]), .MULTI_KEY_SEL(msel),
    .RUN_ENABLE_USED(en_used), .RUN_ENABLE_INPUT(en_in),
    .COMM_RUN_FWD(comm[0]), .COMM_RUN_REV(comm[1]), .COMM_STOP(comm[2]),
    .RUN_PREVENT(prev), .POWER_ON_RUN(pwr_run), .TRIP_RESET(trip),
    .RUN_FWD(run_fwd), .RUN_REV(run_rev), .REMOTE_INDICATOR(rem_ind),
    .KEYPAD_SOURCE_INDICATOR(key_ind), .TERMINAL_BLOCKED(blocked));
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %b, wanted %b", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  // Bounded wait for the run outputs to settle on a pair
  task automatic expect_run(input logic f, input logic r);
    int n;
    n = 0;
    while (n < 40 && !(run_fwd === f && run_rev === r))
    begin
      idle(1);
      n++;
    end
    chk(run_fwd, f);
    chk(run_rev, r);
  endtask : expect_run
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    func[10+:5] <= `FUNC_FORWARD;
    func[30+:5] <= `FUNC_REVERSE;
    idle(4);
    for (int s = 3; s <= 5; s++)
    begin
      src <= 3'(s);
      field.send(0);
      expect_run(1'b1, 1'b0);
      field.send(1);
      expect_run(1'b0, 1'b1);
      field.send(2);
      expect_run(1'b0, 1'b0);
    end
    src <= 3'h6;
    field.send(0);
    idle(10);
    chk(run_fwd, 1'b0);
    src <= `SRC_RS485;
    prev <= `PREVENT_FORWARD;
    field.send(0);
    idle(10);
    chk(run_fwd, 1'b0);
    field.send(1);
    expect_run(1'b0, 1'b1);
    prev <= `PREVENT_REVERSE;
    expect_run(1'b0, 1'b0);
    field.send(2);
    prev <= `PREVENT_NONE;
    $display("source and prevention tests done");
    src <= `SRC_KEYPAD;
    field.press(0);
    expect_run(1'b1, 1'b0);
    field.press(2);
    expect_run(1'b0, 1'b0);
    field.press(1);
    expect_run(1'b0, 1'b1);
    field.press(2);
    expect_run(1'b0, 1'b0);
    $display("keypad test done");
    src <= `SRC_TWO_WIRE;
    dly <= 14'h0002;
    field.put(11'h004);
    idle(6);
    chk(run_fwd, 1'b0);
    expect_run(1'b1, 1'b0);
    field.put(11'h044);
    expect_run(1'b0, 1'b0);
    field.put(11'h040);
    expect_run(1'b0, 1'b1);
    field.put(11'h000);
    expect_run(1'b0, 1'b0);
    src <= `SRC_RUN_DIR;
    field.put(11'h004);
    expect_run(1'b1, 1'b0);
    field.put(11'h044);
    expect_run(1'b0, 1'b1);
    field.put(11'h040);
    expect_run(1'b0, 1'b0);
    $display("terminal tests done");
    src <= `SRC_TWO_WIRE;
    field.put(11'h004);
    expect_run(1'b1, 1'b0);
    field.trip_reset();
    expect_run(1'b0, 1'b0);
    idle(30);
    chk(run_fwd, 1'b0);
    chk(blocked, 1'b1);
    field.put(11'h000);
    idle(6);
    field.put(11'h004);
    expect_run(1'b1, 1'b0);
    $display("trip reset test done");
    msel <= `MULTI_KEY_LOCAL_REMOTE;
    idle(6);
    chk(rem_ind, 1'b1);
    field.press(3);
    expect_run(1'b0, 1'b0);
    chk(rem_ind, 1'b0);
    chk(key_ind, 1'b1);
    en_used <= 1'b1;
    field.press(1);
    idle(10);
    chk(run_rev, 1'b0);
    en_in <= 1'b1;
    field.press(0);
    expect_run(1'b1, 1'b0);
    field.put(11'h040);
    field.press(3);
    expect_run(1'b0, 1'b1);
    chk(rem_ind, 1'b1);
    field.put(11'h000);
    src <= `SRC_RS485;
    field.send(0);
    expect_run(1'b1, 1'b0);
    field.press(3);
    field.press(3);
    idle(10);
    chk(run_fwd, 1'b0);
    $display("local and remote test done");
    // Inching and premagnetise inputs held through a reset with power-on run off
    src <= `SRC_TWO_WIRE;
    pwr_run <= 1'b0;
    inch_f <= 1'b1;
    inch_r <= 1'b1;
    premag <= 1'b1;
    reset <= 1'b1;
    idle(3);
    reset <= 1'b0;
    idle(10);
    chk(blocked, 1'b1);
    inch_f <= 1'b0;
    idle(6);
    chk(blocked, 1'b1);
    inch_r <= 1'b0;
    idle(6);
    chk(blocked, 1'b1);
    field.put(11'h004);
    idle(30);
    chk(run_fwd, 1'b0);
    premag <= 1'b0;
    idle(6);
    chk(blocked, 1'b1);
    field.put(11'h000);
    idle(6);
    chk(blocked, 1'b0);
    field.put(11'h004);
    expect_run(1'b1, 1'b0);
    // Terminal run held through a reset with power-on run on
    pwr_run <= 1'b1;
    reset <= 1'b1;
    idle(3);
    reset <= 1'b0;
    expect_run(1'b1, 1'b0);
    chk(blocked, 1'b0);
    $display("power-on test done");
    complete_run();
  end
endmodule : run_command_source_selector_test
bind run_command_source_selector run_command_source_selector_chk chk (
  .CLOCK(CLOCK), .RESET(RESET), .CMD_SOURCE(CMD_SOURCE),
  .MULTI_KEY_SEL(MULTI_KEY_SEL), .COMM_RUN_FWD(COMM_RUN_FWD),
  .COMM_RUN_REV(COMM_RUN_REV), .COMM_STOP(COMM_STOP),
  .RUN_PREVENT(RUN_PREVENT), .RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV),
  .REMOTE_INDICATOR(REMOTE_INDICATOR),
  .KEYPAD_SOURCE_INDICATOR(KEYPAD_SOURCE_INDICATOR));
